// ### boot_sum_source.sv
`timescale 1ns/1ps
module boot_sum_source (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Scenario
   input wire logic erased,
   input wire logic cfg_bad,
   input wire logic log_bad,
   // Checksum reports
   output logic cfg_sum_valid,
   output logic [31:0] cfg_sum_calc,
   output logic [31:0] cfg_sum_stored,
   output logic cfg_erased,
   output logic log_sum_valid,
   output logic [31:0] log_sum_calc,
   output logic [31:0] log_sum_stored
);
   logic [3:0] step;

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         step <= 4'h0;
         cfg_sum_valid <= 1'b0;
         log_sum_valid <= 1'b0;
      end
      else
      begin
         if (step != 4'hF)
            step <= step + 4'h1;
         cfg_sum_valid <= (step == 4'h2);
         log_sum_valid <= (step == 4'h6);
      end
   end

   // Outside a report the sums wander, so stale values never look valid
   // Erased flag with matching sums
   assign cfg_erased = cfg_sum_valid ? erased : ~erased;
   assign cfg_sum_calc = cfg_sum_valid ? 32'h5A5A_0F0F : {28'h000_0000, step};
   assign cfg_sum_stored = cfg_sum_valid ? {31'h2D2D_0787, ~cfg_bad} : ~{28'h000_0000, step};
   assign log_sum_calc = log_sum_valid ? 32'h1234_8765 : {step, 28'h000_0000};
   assign log_sum_stored = log_sum_valid ? {31'h091A_43B2, ~log_bad} : ~{step, 28'h000_0000};
endmodule

// ### erase_engine.sv
`timescale 1ns/1ps
module erase_engine #(
   parameter int PAGE_CYC = 5000,
   parameter int MASS_CYC = 10000
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Request
   input wire logic page_req,
   input wire logic mass_req,
   // Status
   output logic busy,
   output logic done
);
   flash_ctl_pkg::erase_e state_ff, nxt_state;
   logic [flash_ctl_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
   logic done_ff, nxt_done;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_done = 1'b0;
      case (state_ff)
         flash_ctl_pkg::ST_IDLE:
         begin
            // Mass takes priority over page
            if (mass_req)
            begin
               nxt_state = flash_ctl_pkg::ST_MASS;
               nxt_cnt = flash_ctl_pkg::CNT_W'(MASS_CYC - 1);
            end
            else if (page_req)
            begin
               nxt_state = flash_ctl_pkg::ST_PAGE;
               nxt_cnt = flash_ctl_pkg::CNT_W'(PAGE_CYC - 1);
            end
         end
         flash_ctl_pkg::ST_PAGE, flash_ctl_pkg::ST_MASS:
         begin
            if (cnt_ff == '0)
            begin
               nxt_state = flash_ctl_pkg::ST_IDLE;
               nxt_done = 1'b1;
            end
            else
               nxt_cnt = cnt_ff - 1'b1;
         end
         default:
            nxt_state = flash_ctl_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff <= flash_ctl_pkg::ST_IDLE;
         cnt_ff <= '0;
         done_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         done_ff <= nxt_done;
      end
   end

   assign busy = (state_ff != flash_ctl_pkg::ST_IDLE);
   assign done = done_ff;
endmodule

// ### flash_ctl.sv
`timescale 1ns/1ps
// What this block does
// - At power-up, checksum config section and compare with stored checksum.
// - On config mismatch, load fallback configuration with nothing defined.
// - Fallback identification commands 0x99-0x9E hold fixed strings; serial 000000.
// - Fallback load sets status word bit 2.
// - Erased data flash always fails the config checksum.
// - Store-all-defaults regenerates config checksum.
// - Log checksum updated on each log event or host clear.
// - Bad log checksum at power-up clears logs and sets status bit 7.
// - RAM lies at 0x19000, 4kB.
// - Code flash at 0 or 0x10000 (ROM mode); data flash 0x18800, 2kB.
// - Flash and RAM accesses complete in a single cycle, no cache.
// - Code control bit 11 reads 1 while code flash busy.
// - Bit 10 selects information block instead of main array.
// - Code bit 9 erases selected page, clears when done.
// - Code bit 8 erases whole array, clears when done.
// - Code page index bits 4:0, reset zero; bits 7:5 reserved (stored and read back here, not forced to zero).
// - Data control bit 11 reads 1 while data flash busy.
// - Data bit 9 erases selected page, clears when done.
// - Data bit 8 erases whole data flash, clears when done.
// - Data page index bits 5:0, reset zero; bits 7:6 reserved.
// - Code flash writes need unlock key; key clears after a write.
module flash_ctl (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   // Processor memory port
   input wire logic mem_req,
   input wire logic mem_wr,
   input wire logic [31:0] mem_addr,
   input wire logic rom_mode,
   output logic mem_hit_ram,
   output logic mem_hit_code,
   output logic mem_hit_param,
   output logic mem_ack,
   output logic code_wr_allowed,
   // Integrity checks
   input wire logic cfg_sum_valid,
   input wire logic [31:0] cfg_sum_calc,
   input wire logic [31:0] cfg_sum_stored,
   input wire logic cfg_erased,
   input wire logic store_defaults,
   input wire logic [31:0] cfg_sum_new,
   input wire logic log_sum_valid,
   input wire logic [31:0] log_sum_calc,
   input wire logic [31:0] log_sum_stored,
   input wire logic log_event,
   input wire logic log_clear,
   input wire logic [7:0] id_cmd,
   output logic [31:0] cfg_sum_write,
   output logic cfg_sum_write_en,
   output logic log_sum_update,
   output logic log_wipe,
   output logic load_fallback,
   output logic boot_done,
   output logic [47:0] id_default,
   output logic [15:0] vendor_status_word,
   // Flash array control
   output logic code_info_block_select,
   output logic param_info_block_select,
   output logic [4:0] code_erase_page,
   output logic [5:0] param_erase_page
);
   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   logic code_info_ff, nxt_code_info;
   logic param_info_ff, nxt_param_info;
   logic code_pe_ff, nxt_code_pe, code_me_ff, nxt_code_me;
   logic param_pe_ff, nxt_param_pe, param_me_ff, nxt_param_me;
   logic [7:0] code_low_ff, nxt_code_low;
   logic [5:0] param_page_ff, nxt_param_page;
   logic [31:0] key_ff, nxt_key;
   logic [31:0] rdata_ff, nxt_rdata;
   logic code_busy, code_done, param_busy, param_done;
   logic code_start_pe, code_start_me, param_start_pe, param_start_me;
   logic wr_code, wr_param, wr_key;

   function automatic logic in_range(input logic [31:0] a, input logic [31:0] base, input logic [31:0] size);
      in_range = (a >= base) && (a < base + size);
   endfunction

   assign wr_code = reg_wr && (reg_addr == flash_ctl_pkg::CODE_FLASH_CONTROL_ADDR);
   assign wr_param = reg_wr && (reg_addr == flash_ctl_pkg::PARAM_FLASH_CONTROL_ADDR);
   assign wr_key = reg_wr && (reg_addr == flash_ctl_pkg::CODE_FLASH_UNLOCK_ADDR);

   assign code_start_pe = wr_code && !code_busy && reg_wdata[flash_ctl_pkg::PAGE_ERASE_BIT];
   assign code_start_me = wr_code && !code_busy && reg_wdata[flash_ctl_pkg::MASS_ERASE_BIT];
   assign param_start_pe = wr_param && !param_busy && reg_wdata[flash_ctl_pkg::PAGE_ERASE_BIT];
   assign param_start_me = wr_param && !param_busy && reg_wdata[flash_ctl_pkg::MASS_ERASE_BIT];

   erase_engine #(
      .PAGE_CYC(flash_ctl_pkg::PAGE_ERASE_CYC),
      .MASS_CYC(flash_ctl_pkg::MASS_ERASE_CYC)
   ) u_code_erase (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .page_req(code_start_pe),
      .mass_req(code_start_me),
      .busy(code_busy),
      .done(code_done)
   );

   erase_engine #(
      .PAGE_CYC(flash_ctl_pkg::PAGE_ERASE_CYC),
      .MASS_CYC(flash_ctl_pkg::MASS_ERASE_CYC)
   ) u_param_erase (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .page_req(param_start_pe),
      .mass_req(param_start_me),
      .busy(param_busy),
      .done(param_done)
   );

   function automatic logic mem_hit_code_c();
      mem_hit_code_c = in_range(mem_addr, rom_mode ? flash_ctl_pkg::CODE_BASE_ROM : flash_ctl_pkg::CODE_BASE_PROG,
                                flash_ctl_pkg::CODE_SIZE);
   endfunction

   always_comb
   begin
      nxt_code_info = code_info_ff;
      nxt_param_info = param_info_ff;
      nxt_code_low = code_low_ff;
      nxt_param_page = param_page_ff;
      nxt_code_pe = code_pe_ff;
      nxt_code_me = code_me_ff;
      nxt_param_pe = param_pe_ff;
      nxt_param_me = param_me_ff;
      nxt_key = key_ff;
      nxt_rdata = rdata_ff;
      if (wr_code)
      begin
         nxt_code_info = reg_wdata[flash_ctl_pkg::INFO_BIT];
         if (!code_busy)
            nxt_code_low = reg_wdata[7:0];
      end
      if (wr_param)
      begin
         nxt_param_info = reg_wdata[flash_ctl_pkg::INFO_BIT];
         if (!param_busy)
            nxt_param_page = reg_wdata[flash_ctl_pkg::PARAM_PAGE_W-1:0];
      end
      if (code_done)
         nxt_code_pe = 1'b0;
      if (code_start_pe && !code_start_me)
         nxt_code_pe = 1'b1;
      if (code_done)
         nxt_code_me = 1'b0;
      if (code_start_me)
         nxt_code_me = 1'b1;
      if (param_done)
         nxt_param_pe = 1'b0;
      if (param_start_pe && !param_start_me)
         nxt_param_pe = 1'b1;
      if (param_done)
         nxt_param_me = 1'b0;
      if (param_start_me)
         nxt_param_me = 1'b1;
      if (mem_req && mem_wr && mem_hit_code_c())
         nxt_key = flash_ctl_pkg::ZERO_WORD;
      if (wr_key)
         nxt_key = reg_wdata;
      // Request bits masked by busy: they clear one cycle after the engine idles
      if (reg_rd)
      begin
         nxt_rdata = flash_ctl_pkg::ZERO_WORD;
         if (reg_addr == flash_ctl_pkg::CODE_FLASH_CONTROL_ADDR)
            nxt_rdata[11:0] = {code_busy, code_info_ff, code_pe_ff & code_busy, code_me_ff & code_busy, code_low_ff};
         else if (reg_addr == flash_ctl_pkg::PARAM_FLASH_CONTROL_ADDR)
            nxt_rdata[11:0] = {param_busy, param_info_ff, param_pe_ff & param_busy, param_me_ff & param_busy, 2'b00,
                               param_page_ff};
         else if (reg_addr == flash_ctl_pkg::CODE_FLASH_UNLOCK_ADDR)
            nxt_rdata = key_ff;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         code_info_ff <= 1'b0;
         param_info_ff <= 1'b0;
         code_low_ff <= 8'h00;
         param_page_ff <= 6'h00;
         code_pe_ff <= 1'b0;
         code_me_ff <= 1'b0;
         param_pe_ff <= 1'b0;
         param_me_ff <= 1'b0;
         key_ff <= flash_ctl_pkg::ZERO_WORD;
         rdata_ff <= flash_ctl_pkg::ZERO_WORD;
      end
      else
      begin
         code_info_ff <= nxt_code_info;
         param_info_ff <= nxt_param_info;
         code_low_ff <= nxt_code_low;
         param_page_ff <= nxt_param_page;
         code_pe_ff <= nxt_code_pe;
         code_me_ff <= nxt_code_me;
         param_pe_ff <= nxt_param_pe;
         param_me_ff <= nxt_param_me;
         key_ff <= nxt_key;
         rdata_ff <= nxt_rdata;
      end
   end

   // ------------------------------------------------------------
   // Memory decode, one-cycle answer
   // ------------------------------------------------------------
   logic hit_ram_ff, hit_code_ff, hit_param_ff, ack_ff, wr_ok_ff;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hit_ram_ff <= 1'b0;
         hit_code_ff <= 1'b0;
         hit_param_ff <= 1'b0;
         ack_ff <= 1'b0;
         wr_ok_ff <= 1'b0;
      end
      else
      begin
         hit_ram_ff <= mem_req && in_range(mem_addr, flash_ctl_pkg::RAM_BASE, flash_ctl_pkg::RAM_SIZE);
         hit_code_ff <= mem_req && mem_hit_code_c();
         hit_param_ff <= mem_req && in_range(mem_addr, flash_ctl_pkg::PARAM_BASE, flash_ctl_pkg::PARAM_SIZE);
         ack_ff <= mem_req;
         wr_ok_ff <= mem_req && mem_wr && mem_hit_code_c() && (key_ff == flash_ctl_pkg::UNLOCK_KEY) && !code_busy;
      end
   end

   // ------------------------------------------------------------
   // Power-up integrity checks
   // ------------------------------------------------------------
   flash_ctl_pkg::boot_e boot_ff, nxt_boot;
   logic fallback_ff, nxt_fallback, logbad_ff, nxt_logbad;
   logic load_ff, nxt_load, wipe_ff, nxt_wipe, done_ff, nxt_done;
   logic sumwr_ff, nxt_sumwr, logupd_ff, nxt_logupd;
   logic [31:0] sumval_ff, nxt_sumval;

   always_comb
   begin
      nxt_boot = boot_ff;
      nxt_fallback = fallback_ff;
      nxt_logbad = logbad_ff;
      nxt_load = 1'b0;
      nxt_wipe = 1'b0;
      nxt_done = done_ff;
      nxt_sumwr = 1'b0;
      nxt_sumval = sumval_ff;
      nxt_logupd = 1'b0;
      case (boot_ff)
         flash_ctl_pkg::BT_CFG:
            if (cfg_sum_valid)
            begin
               nxt_boot = flash_ctl_pkg::BT_LOG;
               if (cfg_erased || (cfg_sum_calc != cfg_sum_stored))
               begin
                  nxt_load = 1'b1;
                  nxt_fallback = 1'b1;
               end
            end
         flash_ctl_pkg::BT_LOG:
            if (log_sum_valid)
            begin
               nxt_boot = flash_ctl_pkg::BT_RUN;
               nxt_done = 1'b1;
               if (log_sum_calc != log_sum_stored)
               begin
                  nxt_wipe = 1'b1;
                  nxt_logbad = 1'b1;
               end
            end
         flash_ctl_pkg::BT_RUN:
         begin
            if (store_defaults)
            begin
               nxt_sumwr = 1'b1;
               nxt_sumval = cfg_sum_new;
            end
            nxt_logupd = log_event || log_clear;
         end
         default:
            nxt_boot = flash_ctl_pkg::BT_CFG;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         boot_ff <= flash_ctl_pkg::BT_CFG;
         fallback_ff <= 1'b0;
         logbad_ff <= 1'b0;
         load_ff <= 1'b0;
         wipe_ff <= 1'b0;
         done_ff <= 1'b0;
         sumwr_ff <= 1'b0;
         sumval_ff <= flash_ctl_pkg::ZERO_WORD;
         logupd_ff <= 1'b0;
      end
      else
      begin
         boot_ff <= nxt_boot;
         fallback_ff <= nxt_fallback;
         logbad_ff <= nxt_logbad;
         load_ff <= nxt_load;
         wipe_ff <= nxt_wipe;
         done_ff <= nxt_done;
         sumwr_ff <= nxt_sumwr;
         sumval_ff <= nxt_sumval;
         logupd_ff <= nxt_logupd;
      end
   end

   logic [47:0] id_ff;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         id_ff <= 48'h0000_0000_0000;
      else if (id_cmd == flash_ctl_pkg::CMD_ID_LAST)
         id_ff <= flash_ctl_pkg::SERIAL_DEFAULT;
      else if (id_cmd >= flash_ctl_pkg::CMD_ID_FIRST && id_cmd < flash_ctl_pkg::CMD_ID_LAST)
         id_ff <= {40'h00_0000_0000, id_cmd};
      else
         id_ff <= 48'h0000_0000_0000;
   end

   assign reg_rdata = rdata_ff;
   assign mem_hit_ram = hit_ram_ff;
   assign mem_hit_code = hit_code_ff;
   assign mem_hit_param = hit_param_ff;
   assign mem_ack = ack_ff;
   assign code_wr_allowed = wr_ok_ff;
   assign cfg_sum_write = sumval_ff;
   assign cfg_sum_write_en = sumwr_ff;
   assign log_sum_update = logupd_ff;
   assign log_wipe = wipe_ff;
   assign load_fallback = load_ff;
   assign boot_done = done_ff;
   assign id_default = id_ff;
   assign vendor_status_word = {8'h00, logbad_ff, 4'h0, fallback_ff, 2'b00};
   assign code_info_block_select = code_info_ff;
   assign param_info_block_select = param_info_ff;
   assign code_erase_page = code_low_ff[flash_ctl_pkg::CODE_PAGE_W-1:0];
   assign param_erase_page = param_page_ff;
endmodule

// ### flash_ctl_assertions.sv
`timescale 1ns/1ps
module flash_ctl_checker (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Memory port
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   input wire logic rom_mode,
   input wire logic mem_hit_ram,
   input wire logic mem_hit_code,
   input wire logic mem_hit_param,
   input wire logic mem_ack,
   // Integrity checks
   input wire logic cfg_sum_valid,
   input wire logic [31:0] cfg_sum_calc,
   input wire logic [31:0] cfg_sum_stored,
   input wire logic cfg_erased,
   input wire logic store_defaults,
   input wire logic [31:0] cfg_sum_new,
   input wire logic log_event,
   input wire logic log_clear,
   input wire logic [7:0] id_cmd,
   input wire logic [31:0] cfg_sum_write,
   input wire logic cfg_sum_write_en,
   input wire logic log_sum_update,
   input wire logic load_fallback,
   input wire logic boot_done,
   input wire logic [47:0] id_default,
   input wire logic [15:0] vendor_status_word
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   ack_single_a : assert property (mem_req |=> mem_ack)
      else $error("memory ack late");
   ram_hit_a : assert property (mem_req && mem_addr >= flash_ctl_pkg::RAM_BASE
      && mem_addr < flash_ctl_pkg::RAM_BASE + flash_ctl_pkg::RAM_SIZE |=> mem_hit_ram && !mem_hit_code)
      else $error("ram window miss");
   code_hit_a : assert property (mem_req && !rom_mode && mem_addr < flash_ctl_pkg::CODE_SIZE
      |=> mem_hit_code && !mem_hit_param)
      else $error("code window miss");
   param_hit_a : assert property (mem_req && mem_addr >= flash_ctl_pkg::PARAM_BASE
      && mem_addr < flash_ctl_pkg::PARAM_BASE + flash_ctl_pkg::PARAM_SIZE |=> mem_hit_param)
      else $error("param window miss");
   bad_config_a : assert property (!boot_done && cfg_sum_valid
      && (cfg_erased || cfg_sum_calc != cfg_sum_stored) |-> ##[1:2] load_fallback)
      else $error("fallback not loaded");
   fallback_flag_a : assert property (load_fallback |-> ##[0:1] vendor_status_word[2])
      else $error("fallback flag missing");
   log_flag_held_a : assert property (vendor_status_word[7] |=> vendor_status_word[7])
      else $error("log flag dropped");
   sum_regen_a : assert property (store_defaults && boot_done
      |=> cfg_sum_write_en && cfg_sum_write == $past(cfg_sum_new))
      else $error("config sum not rewritten");
   log_sum_a : assert property ((log_event || log_clear) && boot_done |=> log_sum_update)
      else $error("log sum not updated");
   serial_default_a : assert property (id_cmd == 8'h9E |=> id_default == 48'h3030_3030_3030)
      else $error("serial default wrong");
endmodule

bind flash_ctl flash_ctl_checker chk (.ref_clk, .rst_n, .mem_req, .mem_addr, .rom_mode, .mem_hit_ram,
   .mem_hit_code, .mem_hit_param, .mem_ack, .cfg_sum_valid, .cfg_sum_calc, .cfg_sum_stored, .cfg_erased,
   .store_defaults, .cfg_sum_new, .log_event, .log_clear, .id_cmd, .cfg_sum_write, .cfg_sum_write_en,
   .log_sum_update, .load_fallback, .boot_done, .id_default, .vendor_status_word);

// ### flash_ctl_pkg.sv
package flash_ctl_pkg;

   // ------------------------------------------------------------
   // Register addresses (byte addresses as printed)
   // ------------------------------------------------------------
   localparam logic [31:0] CODE_FLASH_CONTROL_ADDR = 32'hFFFF_FE60;
   localparam logic [31:0] PARAM_FLASH_CONTROL_ADDR = 32'h0FFF_FE64;
   localparam logic [31:0] CODE_FLASH_UNLOCK_ADDR = 32'h0FFF_FE68;

   // ------------------------------------------------------------
   // Memory map
   // ------------------------------------------------------------
   localparam logic [31:0] RAM_BASE = 32'h0001_9000;
   localparam logic [31:0] RAM_SIZE = 32'h0000_1000;
   localparam logic [31:0] CODE_BASE_PROG = 32'h0000_0000;
   localparam logic [31:0] CODE_BASE_ROM = 32'h0001_0000;
   localparam logic [31:0] CODE_SIZE = 32'h0000_8000;
   localparam logic [31:0] PARAM_BASE = 32'h0001_8800;
   localparam logic [31:0] PARAM_SIZE = 32'h0000_0800;

   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam int BUSY_BIT = 11;
   localparam int INFO_BIT = 10;
   localparam int PAGE_ERASE_BIT = 9;
   localparam int MASS_ERASE_BIT = 8;
   localparam int CODE_PAGE_W = 5;
   localparam int PARAM_PAGE_W = 6;
   localparam logic [31:0] UNLOCK_KEY = 32'h42DC_157E;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

   // ------------------------------------------------------------
   // Status word bits
   // ------------------------------------------------------------
   localparam int STAT_FALLBACK_BIT = 2;
   localparam int STAT_LOG_BAD_BIT = 7;

   // ------------------------------------------------------------
   // Erase timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int PAGE_ERASE_US = 20;
   localparam int MASS_ERASE_US = 40;
   localparam int PAGE_ERASE_CYC = PAGE_ERASE_US * CLK_MHZ;
   localparam int MASS_ERASE_CYC = MASS_ERASE_US * CLK_MHZ;
   localparam int CNT_W = 16;

   // ------------------------------------------------------------
   // Fallback identification strings (block command codes)
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_ID_FIRST = 8'h99;
   localparam logic [7:0] CMD_ID_LAST = 8'h9E;
   localparam logic [47:0] SERIAL_DEFAULT = 48'h3030_3030_3030;

   typedef enum {ST_IDLE, ST_PAGE, ST_MASS} erase_e;
   typedef enum {BT_CFG, BT_LOG, BT_RUN} boot_e;

endpackage

// ### flash_ctl_tb.sv
`timescale 1ns/1ps
module flash_ctl_tb;
   logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, mem_req = 1'b0, mem_wr = 1'b0;
   logic rom_mode = 1'b0, store_defaults = 1'b0, log_event = 1'b0, log_clear = 1'b0;
   logic erased = 1'b0, cfg_bad = 1'b0, log_bad = 1'b0;
   logic [31:0] reg_addr = 32'h0000_0000, reg_wdata = 32'h0000_0000, mem_addr = 32'h0000_0000;
   logic [31:0] cfg_sum_new = 32'h0000_0000, reg_rdata, cfg_sum_write;
   logic [31:0] cfg_sum_calc, cfg_sum_stored, log_sum_calc, log_sum_stored;
   logic [7:0] id_cmd = 8'h00;
   logic mem_hit_ram, mem_hit_code, mem_hit_param, mem_ack, code_wr_allowed, cfg_sum_valid, cfg_erased;
   logic log_sum_valid, cfg_sum_write_en, log_sum_update, log_wipe, load_fallback, boot_done;
   logic code_info_block_select, param_info_block_select;
   logic [47:0] id_default;
   logic [15:0] vendor_status_word;
   logic [4:0] code_erase_page;
   logic [5:0] param_erase_page;
   logic [31:0] rv;
   logic [31:0] rows [4][2];
   int err_count = 0;
   int comparisons = 0;
   int polls;
   localparam logic [31:0] CA = flash_ctl_pkg::CODE_FLASH_CONTROL_ADDR;
   localparam logic [31:0] PA = flash_ctl_pkg::PARAM_FLASH_CONTROL_ADDR;

   always #2 ref_clk = ~ref_clk;

   flash_ctl dut (.ref_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .mem_req, .mem_wr,
      .mem_addr, .rom_mode, .mem_hit_ram, .mem_hit_code, .mem_hit_param, .mem_ack, .code_wr_allowed,
      .cfg_sum_valid, .cfg_sum_calc, .cfg_sum_stored, .cfg_erased, .store_defaults, .cfg_sum_new,
      .log_sum_valid, .log_sum_calc, .log_sum_stored, .log_event, .log_clear, .id_cmd, .cfg_sum_write,
      .cfg_sum_write_en, .log_sum_update, .log_wipe, .load_fallback, .boot_done, .id_default,
      .vendor_status_word, .code_info_block_select, .param_info_block_select, .code_erase_page,
      .param_erase_page);

   boot_sum_source far (.ref_clk, .rst_n, .erased, .cfg_bad, .log_bad, .cfg_sum_valid, .cfg_sum_calc,
      .cfg_sum_stored, .cfg_erased, .log_sum_valid, .log_sum_calc, .log_sum_stored);

   // ----------------
   // Tasks
   // ----------------
   task automatic summarize;
      if (err_count == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask

   task automatic stuck(input string what);
      err_count++;
      $display("BAD %s exp done got timeout", what);
      summarize;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(negedge ref_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask

   task automatic peek(input logic [31:0] a);
      @(negedge ref_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      @(negedge ref_clk);
      rv = reg_rdata;
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      peek(a);
      chk("control reg", 48'(exp), 48'(rv));
   endtask

   task automatic pulse(input logic [1:0] which);
      @(negedge ref_clk);
      store_defaults = which[0] & which[1];
      log_event = which[0] & ~which[1];
      log_clear = which[1] & ~which[0];
      @(negedge ref_clk);
      {store_defaults, log_event, log_clear} = 3'b000;
   endtask

   task automatic boot(input logic e, input logic c, input logic l, input logic [15:0] exp);
      @(negedge ref_clk);
      rst_n = 1'b0;
      {erased, cfg_bad, log_bad} = {e, c, l};
      repeat (4) @(negedge ref_clk);
      rst_n = 1'b1;
      for (polls = 0; boot_done !== 1'b1 && polls < 100; polls++)
         @(negedge ref_clk);
      if (polls == 100)
         stuck("boot");
      chk("status word", 48'(exp), 48'(vendor_status_word));
      chk("log wipe", 48'(l), 48'(log_wipe));
   endtask

   task automatic probe(input logic [31:0] a, input logic rom, input logic w, input logic [4:0] exp);
      @(negedge ref_clk);
      {mem_req, mem_wr, rom_mode, mem_addr} = {1'b1, w, rom, a};
      @(negedge ref_clk);
      {mem_req, mem_wr} = 2'b00;
      chk("memory hit", 48'(exp), 48'({mem_hit_ram, mem_hit_code, mem_hit_param, mem_ack, code_wr_allowed}));
   endtask

   // ----------------
   // Sequence
   // ----------------
   initial
   begin
      boot(1'b1, 1'b0, 1'b0, 16'h0004);
      boot(1'b0, 1'b1, 1'b1, 16'h0084);
      boot(1'b0, 1'b0, 1'b0, 16'h0000);
      rd(CA, 32'h0000_0000);
      rd(PA, 32'h0000_0000);
      rd(32'h0000_0100, 32'h0000_0000);
      for (int i = 0; i < 6; i++)
      begin
         @(negedge ref_clk);
         id_cmd = 8'h99 + 8'(i);
         @(negedge ref_clk);
         chk("id default", (i == 5) ? 48'h3030_3030_3030 : 48'(id_cmd), id_default);
      end
      cfg_sum_new = 32'hC0DE_0042;
      pulse(2'b11);
      chk("sum write", 48'({1'b1, 32'hC0DE_0042}), 48'({cfg_sum_write_en, cfg_sum_write}));
      pulse(2'b01);
      chk("log sum", 48'h1, 48'(log_sum_update));
      pulse(2'b10);
      chk("log sum", 48'h1, 48'(log_sum_update));
      probe(32'h0001_9000, 1'b0, 1'b0, 5'b10010);
      probe(32'h0001_9FFF, 1'b0, 1'b0, 5'b10010);
      probe(32'h0001_A000, 1'b0, 1'b0, 5'b00010);
      probe(32'h0001_8800, 1'b0, 1'b0, 5'b00110);
      probe(32'h0001_8FFF, 1'b0, 1'b0, 5'b00110);
      probe(32'h0001_0000, 1'b1, 1'b0, 5'b01010);
      probe(32'h0000_0100, 1'b0, 1'b1, 5'b01010);
      wr(flash_ctl_pkg::CODE_FLASH_UNLOCK_ADDR, 32'h42DC_157F);
      probe(32'h0000_0100, 1'b0, 1'b1, 5'b01010);
      wr(flash_ctl_pkg::CODE_FLASH_UNLOCK_ADDR, 32'h42DC_157E);
      probe(32'h0000_0100, 1'b0, 1'b1, 5'b01011);
      probe(32'h0000_0104, 1'b0, 1'b1, 5'b01010);
      rows = '{'{CA, 32'h0000_0500}, '{CA, 32'h0000_0613}, '{PA, 32'h0000_023F}, '{PA, 32'h0000_013F}};
      for (int i = 0; i < 4; i++)
      begin
         wr(rows[i][0], rows[i][1]);
         rd(rows[i][0], rows[i][1] | 32'h0000_0800);
         // Info bit kept: it stays writable while busy, so only refused fields flip
         wr(rows[i][0], rows[i][1] ^ 32'h0000_0301);
         rd(rows[i][0], rows[i][1] | 32'h0000_0800);
         for (polls = 0; rv[11] !== 1'b0 && polls < 4000; polls++)
            peek(rows[i][0]);
         if (polls == 4000)
            stuck("erase");
         chk("erase done", 48'(rows[i][1] & 32'h0000_04FF), 48'(rv));
      end
      chk("flash pins", 48'h1000_0000_133F,
         48'({code_info_block_select, 3'b000, param_info_block_select, 27'h0, code_erase_page, 2'b00, param_erase_page}));
      summarize;
   end
endmodule
